// ---- src/cos_defines.svh ----
`ifndef COS_DEFINES_SVH
`define COS_DEFINES_SVH

// register byte addresses
`define COS_OFS_OVERRIDE   12'h000
`define COS_OFS_SECURE     12'h004
`define COS_OFS_SPEC       12'h008

// byte address width used for decode
`define COS_AW             12

// control override field positions
`define COS_OVR_PRIO_BIT   4
`define COS_OVR_BARR_BIT   3
`define COS_OVR_SPEC_BIT   2
`define COS_OVR_DVM_BIT    1
`define COS_OVR_SNOOP_BIT  0
`define COS_OVR_WIDTH      5
`define COS_OVR_RESET      5'h00

// speculation control field positions
`define COS_SPEC_SLV_LSB   16
`define COS_SPEC_SLV_MSB   20
`define COS_SPEC_MST_LSB   0
`define COS_SPEC_MST_MSB   2
`define COS_SPEC_SLV_RESET 5'h00
`define COS_SPEC_MST_RESET 3'h0

// secure access register
`define COS_SEC_NSACC_BIT  0
`define COS_SEC_RESET      1'h0

// interface counts
`define COS_NUM_SLV        5
`define COS_NUM_MST        3

// ahb encodings
`define COS_HTRANS_NONSEQ  2'h2
`define COS_HTRANS_SEQ     2'h3

`endif

// ---- src/cos_pkg.sv ----
`include "cos_defines.svh"

package cos_pkg;

    // control override register fields, msb first
    typedef struct packed {
        logic prio_promote_disable;
        logic terminate_all_barriers;
        logic spec_disable;
        logic dvm_disable;
        logic snoop_disable;
    } cos_ovr_s;

    // effective controls driven into the interconnect logic
    typedef struct packed {
        logic [`COS_NUM_SLV-1:0] qos_promote;
        logic [`COS_NUM_MST-1:0] barrier_terminate;
        logic [`COS_NUM_SLV-1:0] snoop_enable;
        logic [`COS_NUM_SLV-1:0] dvm_enable;
        logic [`COS_NUM_SLV-1:0] slave_spec_enable;
        logic [`COS_NUM_MST-1:0] master_spec_enable;
    } cos_ctrl_s;

    // pending ahb data phase
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  nonsec;
        logic [`COS_AW-1:0]    addr;
    } cos_dphase_s;

endpackage

// ---- src/cos_ctrl.sv ----
`timescale 1ns/1ps
`include "cos_defines.svh"


module cos_ctrl (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hnonsec,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // pin inputs from outside the clock domain
    input  wire logic [`COS_NUM_SLV-1:0] qos_arbitration_promote_inputs,
    input  wire logic [`COS_NUM_MST-1:0] barrier_termination_select,
    // per-interface enables from the snoop control registers, same clock
    input  wire logic [`COS_NUM_SLV-1:0] snoop_enable_in,
    input  wire logic [`COS_NUM_SLV-1:0] dvm_enable_in,
    // speculative fetch query for one transaction
    input  wire logic [`COS_NUM_SLV-1:0] fetch_slave_sel,
    input  wire logic [`COS_NUM_MST-1:0] fetch_master_sel,
    output logic                         fetch_spec_allow,
    // effective controls and raw register bits
    output cos_pkg::cos_ctrl_s           ctrl,
    output cos_pkg::cos_ovr_s            override_bits,
    output logic                         nonsec_access_enable
);

    // whole state of the block in one struct
    typedef struct packed {
        cos_pkg::cos_ovr_s       ovr;
        logic [`COS_NUM_SLV-1:0] spec_slv_dis;
        logic [`COS_NUM_MST-1:0] spec_mst_dis;
        logic                    nsacc;
        cos_pkg::cos_dphase_s    dp;
        logic [31:0]             rdata;
        logic [`COS_NUM_SLV-1:0] qos_meta;
        logic [`COS_NUM_SLV-1:0] qos_sync;
        logic [`COS_NUM_MST-1:0] barr_meta;
        logic [`COS_NUM_MST-1:0] barr_sync;
        cos_pkg::cos_ctrl_s      ctrl;
    } cos_state_s;

    cos_state_s st;
    cos_state_s next_st;

    // access permission per register, evaluated for the data phase owner
    function automatic logic wr_allowed(
        input logic [`COS_AW-1:0] a,
        input logic               ns,
        input logic               nsacc
    );
        logic ok;
        ok = 1'b0;
        case (a)
            `COS_OFS_OVERRIDE: ok = !ns;
            `COS_OFS_SECURE:   ok = !ns;
            `COS_OFS_SPEC:     ok = !ns || nsacc;
            default:           ok = 1'b0;
        endcase
        return ok;
    endfunction

    // reads of the secure access bit are open to all; the others follow write rules
    function automatic logic rd_allowed(
        input logic [`COS_AW-1:0] a,
        input logic               ns,
        input logic               nsacc
    );
        logic ok;
        ok = 1'b0;
        case (a)
            `COS_OFS_SECURE: ok = 1'b1;
            default:         ok = wr_allowed(a, ns, nsacc);
        endcase
        return ok;
    endfunction

    // read mux, reserved bits come back as zero
    function automatic logic [31:0] rd_value(
        input logic [`COS_AW-1:0] a,
        input cos_state_s         s
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `COS_OFS_OVERRIDE: v[`COS_OVR_WIDTH-1:0] = s.ovr;
            `COS_OFS_SECURE:   v[`COS_SEC_NSACC_BIT] = s.nsacc;
            `COS_OFS_SPEC: begin
                v[`COS_SPEC_SLV_MSB:`COS_SPEC_SLV_LSB] = s.spec_slv_dis;
                v[`COS_SPEC_MST_MSB:`COS_SPEC_MST_LSB] = s.spec_mst_dis;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    logic addr_phase;

    // a new transfer is taken only when the bus is ready and it is a nonseq or seq
    assign addr_phase = hsel && hready &&
                        (htrans == `COS_HTRANS_NONSEQ || htrans == `COS_HTRANS_SEQ);

    // next state: write from the data phase, then capture the next address phase
    always_comb begin
        next_st = st;

        // two-flop synchronisers for the strap-like pin inputs
        next_st.qos_meta  = qos_arbitration_promote_inputs;
        next_st.qos_sync  = st.qos_meta;
        next_st.barr_meta = barrier_termination_select;
        next_st.barr_sync = st.barr_meta;

        // data phase write; denied writes leave every bit alone
        if (st.dp.valid && st.dp.write && wr_allowed(st.dp.addr, st.dp.nonsec, st.nsacc)) begin
            case (st.dp.addr)
                `COS_OFS_OVERRIDE: next_st.ovr = hwdata[`COS_OVR_WIDTH-1:0];
                `COS_OFS_SECURE:   next_st.nsacc = hwdata[`COS_SEC_NSACC_BIT];
                `COS_OFS_SPEC: begin
                    next_st.spec_slv_dis = hwdata[`COS_SPEC_SLV_MSB:`COS_SPEC_SLV_LSB];
                    next_st.spec_mst_dis = hwdata[`COS_SPEC_MST_MSB:`COS_SPEC_MST_LSB];
                end
                default: next_st.ovr = st.ovr;   // unmapped writes are dropped
            endcase
        end

        // address phase capture; read data is taken from the post-write
        // values so a read right behind a write sees the new contents
        next_st.dp.valid = addr_phase;
        if (addr_phase) begin
            next_st.dp.write  = hwrite;
            next_st.dp.nonsec = hnonsec;
            next_st.dp.addr   = {haddr[`COS_AW-1:2], 2'h0};
            if (!hwrite && rd_allowed(next_st.dp.addr, hnonsec, next_st.nsacc)) begin
                next_st.rdata = rd_value(next_st.dp.addr, next_st);
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end

        // qos promotion inputs pass only while promotion is enabled
        next_st.ctrl.qos_promote = next_st.ovr.prio_promote_disable ?
                                   '0 : st.qos_sync;

        // barrier termination forced on for every master when overridden
        next_st.ctrl.barrier_terminate = next_st.ovr.terminate_all_barriers ?
                                         '1 : st.barr_sync;

        // snoops and dvm gated independently so one never disables the other
        next_st.ctrl.snoop_enable = next_st.ovr.snoop_disable ? '0 : snoop_enable_in;
        next_st.ctrl.dvm_enable   = next_st.ovr.dvm_disable   ? '0 : dvm_enable_in;

        // per-interface speculation enables under the global kill
        next_st.ctrl.slave_spec_enable  = next_st.ovr.spec_disable ?
                                          '0 : ~next_st.spec_slv_dis;
        next_st.ctrl.master_spec_enable = next_st.ovr.spec_disable ?
                                          '0 : ~next_st.spec_mst_dis;
    end

    // state register; every control bit starts cleared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.ovr          <= `COS_OVR_RESET;
            st.spec_slv_dis <= `COS_SPEC_SLV_RESET;
            st.spec_mst_dis <= `COS_SPEC_MST_RESET;
            st.nsacc        <= `COS_SEC_RESET;
            st.dp           <= '0;
            st.rdata        <= 32'h0000_0000;
            st.qos_meta     <= '0;
            st.qos_sync     <= '0;
            st.barr_meta    <= '0;
            st.barr_sync    <= '0;
            st.ctrl         <= '0;
        end else begin
            st <= next_st;
        end
    end

    // the fetch must be allowed on both the arriving slave and the leaving master;
    // combinational so the speculation path adds no cycle of latency
    always_comb begin
        fetch_spec_allow = |(fetch_slave_sel & st.ctrl.slave_spec_enable) &&
                           |(fetch_master_sel & st.ctrl.master_spec_enable);
    end

    // bus answers: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;

    // register-backed outputs
    assign ctrl                 = st.ctrl;
    assign override_bits        = st.ovr;
    assign nonsec_access_enable = st.nsacc;

endmodule

// ---- tb/cos_ctrl_monitor.sv ----
`timescale 1ns/1ps
module cos_ctrl_monitor (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hnonsec,
    input wire logic               hready,
    input wire logic [4:0]         qos_arbitration_promote_inputs,
    input wire logic [4:0]         fetch_slave_sel,
    input wire logic [2:0]         fetch_master_sel,
    input wire logic               fetch_spec_allow,
    input wire cos_pkg::cos_ctrl_s ctrl,
    input wire cos_pkg::cos_ovr_s  override_bits,
    input wire logic               nonsec_access_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // non-secure write address phase; the store lands one edge after the data phase
    wire logic ns_wr = hsel && hready && htrans[1] && hwrite && hnonsec;
    // the promote inputs are required stable for 4 cycles so the synchroniser latency cannot matter
    AST_QOS_FOLLOW:
        assert property ((!override_bits.prio_promote_disable
            && $stable(qos_arbitration_promote_inputs)) [*4]
            |-> ctrl.qos_promote == qos_arbitration_promote_inputs)
            else $error("qos promote mismatch");
    AST_BARRIER_ALL:
        assert property (override_bits.terminate_all_barriers && $stable(override_bits)
            |-> ctrl.barrier_terminate == 3'h7) else $error("barrier not forced");
    AST_SPEC_GLOBAL:
        assert property (override_bits.spec_disable && $stable(override_bits)
            |-> {ctrl.slave_spec_enable, ctrl.master_spec_enable} == 8'h00)
            else $error("speculation not blocked");
    AST_DVM_OFF:
        assert property (override_bits.dvm_disable && $stable(override_bits)
            |-> ctrl.dvm_enable == 5'h00) else $error("dvm not blocked");
    AST_SNOOP_OFF:
        assert property (override_bits.snoop_disable && $stable(override_bits)
            |-> ctrl.snoop_enable == 5'h00) else $error("snoop not blocked");
    AST_OVR_SECURE:
        assert property (ns_wr && haddr[11:2] == 10'h000 ##1 hready
            |=> $stable(override_bits)) else $error("override took non-secure write");
    AST_FETCH_BOTH:
        assert property (fetch_spec_allow == (|(fetch_slave_sel & ctrl.slave_spec_enable)
            && |(fetch_master_sel & ctrl.master_spec_enable))) else $error("fetch gate wrong");
    AST_NSACC_SECURE:
        assert property (ns_wr && haddr[11:2] == 10'h001 ##1 hready
            |=> $stable(nonsec_access_enable)) else $error("access bit took non-secure write");
endmodule

bind cos_ctrl cos_ctrl_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hnonsec, .hready, .qos_arbitration_promote_inputs, .fetch_slave_sel, .fetch_master_sel,
    .fetch_spec_allow, .ctrl, .override_bits, .nonsec_access_enable);

// ---- tb/coherency_override_spec_ctrl_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module coherency_override_spec_ctrl_test;
    logic               hclk;
    logic               hresetn;
    logic               hsel;
    logic               hwrite;
    logic               hnonsec;
    logic               hreadyout;
    logic               fetch_spec_allow;
    logic               nsacc;
    logic [1:0]         htrans;
    logic [2:0]         barr_sel;
    logic [2:0]         mst_sel;
    logic [4:0]         qos_in;
    logic [4:0]         snp_in;
    logic [4:0]         dvm_in;
    logic [4:0]         slv_sel;
    logic [31:0]        haddr;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic [31:0]        rd;
    logic [31:0]        r;
    logic [31:0]        spx;
    cos_pkg::cos_ctrl_s ctrl;
    cos_pkg::cos_ovr_s  ovr;
    integer             seed;
    integer             miscompares;
    integer             total_checks;
    int                 s;
    int                 m;
    logic               nsx;

    cos_ctrl u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hnonsec,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
        .qos_arbitration_promote_inputs(qos_in), .barrier_termination_select(barr_sel),
        .snoop_enable_in(snp_in), .dvm_enable_in(dvm_in), .fetch_slave_sel(slv_sel),
        .fetch_master_sel(mst_sel), .fetch_spec_allow, .ctrl, .override_bits(ovr),
        .nonsec_access_enable(nsacc));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // one single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic ns, input logic [11:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hnonsec <= ns;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // span is far beyond the roughly 300 cycles the tests need
    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        finish_test();
    end

    initial begin
        {hresetn, hsel, hwrite, hnonsec, htrans, haddr, hwdata} = '0;
        {qos_in, barr_sel, snp_in, dvm_in, slv_sel, mst_sel} = '0;
        {miscompares, total_checks} = '0;
        seed = 32'hB745F4BA;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped word included
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 1'b0, 12'(4 * i), 32'h0);
            `CHK("reset read", 32'h0, rd)
        end
        $display("reset values done");
        // reserved bits stay zero; a non-secure write is refused even with access open
        bus(1'b1, 1'b0, 12'h000, 32'hFFFFFFFF);
        bus(1'b1, 1'b0, 12'h004, 32'h1);
        bus(1'b1, 1'b1, 12'h000, 32'h0);
        bus(1'b0, 1'b0, 12'h000, 32'h0);
        `CHK("override all", 32'h1F, rd)
        `CHK("override bits", 5'h1F, ovr)
        `CHK("spec all off", 8'h00, {ctrl.slave_spec_enable, ctrl.master_spec_enable})
        `CHK("qos off", 5'h00, ctrl.qos_promote)
        `CHK("barrier all", 3'h7, ctrl.barrier_terminate)
        `CHK("dvm off", 5'h00, ctrl.dvm_enable)
        `CHK("snoop off", 5'h00, ctrl.snoop_enable)
        bus(1'b1, 1'b0, 12'h000, 32'h0);
        {qos_in, barr_sel, snp_in, dvm_in} <= 18'($random(seed));
        repeat (4) @(posedge hclk);
        `CHK("qos pass", qos_in, ctrl.qos_promote)
        `CHK("barrier pass", barr_sel, ctrl.barrier_terminate)
        `CHK("dvm pass", dvm_in, ctrl.dvm_enable)
        `CHK("snoop pass", snp_in, ctrl.snoop_enable)
        $display("override done");
        // random security, access, speculation and query mix
        nsx = 1'b1;
        spx = 32'h0;
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            {qos_in, barr_sel, snp_in, dvm_in} <= r[31:14];
            bus(1'b1, r[0], 12'h004, {31'h0, r[1]});
            nsx = r[0] ? nsx : r[1];
            // the access bit lands on the edge that ends the task, so look one transfer later
            bus(1'b1, 1'b0, 12'h000, {29'h0, r[2], 2'h0});
            `CHK("access bit", nsx, nsacc)
            bus(1'b1, r[3], 12'h008, $random(seed));
            spx = (r[3] && !nsx) ? spx : hwdata & 32'h001F0007;
            bus(1'b0, r[4], 12'h008, 32'h0);
            `CHK("spec read", (r[4] && !nsx) ? 32'h0 : spx, rd)
            s = r[7:5] % 5;
            m = r[9:8] % 3;
            slv_sel <= 5'h01 << s;
            mst_sel <= 3'h1 << m;
            @(posedge hclk);
            `CHK("fetch", !r[2] && !spx[16 + s] && !spx[m], fetch_spec_allow)
        end
        $display("speculation done");
        finish_test();
    end
endmodule
